/* common/pic_state_pkg.sv */
// Package: picture-state command field layout and constants
package pic_state_pkg;

  // ----------------------------------------------------------------
  // Command words
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned CMD_WORDS     = 8;
  localparam logic [2:0]  WORD_IDX_PIC  = 3'h3;
  localparam logic [2:0]  WORD_IDX_OUT  = 3'h4;

  // ----------------------------------------------------------------
  // Word 3 field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CMD_SCAN      = 14;
  localparam int unsigned BIT_DATA_SCAN     = 13;
  localparam int unsigned BIT_MONO_WEIGHT   = 12;
  localparam int unsigned BIT_SCALING       = 10;
  localparam int unsigned BIT_STRUCT_HI     = 9;
  localparam int unsigned BIT_STRUCT_LO     = 8;
  localparam int unsigned BIT_FSI_HI        = 7;
  localparam int unsigned BIT_FSI_LO        = 0;
  localparam int unsigned BIT_FSI_TOP_HI    = 7;
  localparam int unsigned BIT_FSI_TOP_LO    = 5;

  // ----------------------------------------------------------------
  // Word 4 field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RESID_HI      = 31;
  localparam int unsigned BIT_RESID_LO      = 24;
  localparam int unsigned BIT_SYNC_OVR      = 17;
  localparam int unsigned BIT_SYNC          = 16;
  localparam int unsigned BIT_SIXTEEN_MV    = 12;
  localparam int unsigned BIT_CHROMA_HI     = 11;
  localparam int unsigned BIT_CHROMA_LO     = 10;
  localparam int unsigned BIT_DEBLOCK       = 8;
  localparam int unsigned BIT_ENTROPY       = 7;
  localparam int unsigned BIT_NON_REF       = 6;
  localparam int unsigned BIT_CONSTR_INTRA  = 5;
  localparam int unsigned BIT_DIRECT_INFER  = 4;
  localparam int unsigned BIT_LARGE_XFORM   = 3;
  localparam int unsigned BIT_FRAME_ONLY    = 2;
  localparam int unsigned BIT_FIELD_PIC     = 0;

  // ----------------------------------------------------------------
  // Encodings and limits
  // ----------------------------------------------------------------
  localparam logic [1:0] STRUCT_FRAME     = 2'h0;
  localparam logic [1:0] STRUCT_TOP       = 2'h1;
  localparam logic [1:0] STRUCT_BAD       = 2'h2;
  localparam logic [1:0] STRUCT_BOTTOM    = 2'h3;
  localparam logic [1:0] CHROMA_MONO      = 2'h0;
  localparam logic [1:0] CHROMA_420       = 2'h1;
  localparam logic [7:0] FSI_WRITE_BASE   = 8'h10;
  localparam logic [7:0] FSI_MAX          = 8'h10;
  localparam logic [6:0] FSI_NONEXIST     = 7'h7F;
  localparam logic [2:0] RESID_ALIGN_MASK = 3'h7;
  localparam logic [2:0] RESID_ALIGN_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    MV_BASE_READ_SET,
    MV_BASE_WRITE_TOP,
    MV_BASE_WRITE_BOTTOM
  } mv_base_sel_t;

endpackage

/* common/pic_state_if.sv */
// Interface: command word link between streamer and picture-state decoder
`timescale 1ns/1ps
interface pic_state_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;
  logic        last;

  modport streamer (output valid, output data, output last, input ready);
  modport decoder  (input valid, input data, input last, output ready);
endinterface

/* verilog/pic_state_decoder.sv */
// Device end: decodes and holds the picture-state command fields
`timescale 1ns/1ps

module pic_state_decoder
  import pic_state_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  // Command link
  pic_state_if.decoder       cmd,
  // Per-macroblock inputs from the decode core
  input  wire logic          i_mb_intra,
  input  wire logic          i_mb_pcm,
  input  wire logic          i_mb_neighbour_avail,
  input  wire logic          i_mb_large_mv,
  // Picture state
  output logic               o_cmd_scan_special,
  output logic               o_data_scan_special,
  output logic               o_scaling_matrix_present,
  output logic               o_scaling_payload_accept,
  output logic               o_use_flat_8x8,
  output logic [1:0]         o_picture_structure,
  output logic               o_field_picture,
  output logic [7:0]         o_current_frame_store_index,
  output logic [4:0]         o_order_count_index,
  output mv_base_sel_t       o_mv_base_select,
  output logic [4:0]         o_mv_read_base_entry,
  output logic [7:0]         o_residual_offset,
  output logic               o_mb_sync,
  output logic               o_sixteen_vector_format_enable,
  output logic               o_mv_size_large,
  output logic [1:0]         o_chroma_sampling_format,
  output logic               o_monochrome,
  output logic               o_deblock_info_write_enable,
  output logic               o_entropy_cabac,
  output logic               o_non_reference_picture,
  output logic               o_constrained_intra,
  output logic               o_direct_block_inference,
  output logic               o_large_transform_allowed,
  output logic               o_state_valid,
  output logic               o_field_error
);
  import pic_state_pkg::*;

  // ----------------------------------------------------------------
  // Word capture
  // ----------------------------------------------------------------
  logic [2:0]  word_idx;
  logic [31:0] pic_word;
  logic [31:0] out_word;
  logic        sync_ovr;
  logic        sync_bit;

  wire         take       = cmd.valid;
  wire         take_pic   = take && (word_idx == WORD_IDX_PIC);
  wire         take_out   = take && (word_idx == WORD_IDX_OUT);
  wire         take_last  = take && cmd.last;
  wire [2:0]   next_idx   = take_last ? 3'h0 : word_idx + 3'h1;

  // Decoder never stalls the streamer; fields latch on the word they arrive in
  assign cmd.ready = 1'b1;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      word_idx <= 3'h0;
    end else if (take) begin
      word_idx <= next_idx;
    end
  end

  // Values held across slices until reset or the next command
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pic_word <= RST_WORD;
      out_word <= RST_WORD;
    end else begin
      if (take_pic) begin
        pic_word <= cmd.data;
      end
      if (take_out) begin
        out_word <= cmd.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [1:0] pic_struct  = pic_word[BIT_STRUCT_HI:BIT_STRUCT_LO];
  wire [7:0] fsi         = pic_word[BIT_FSI_HI:BIT_FSI_LO];
  wire       large_xform = out_word[BIT_LARGE_XFORM];
  wire       frame_only  = out_word[BIT_FRAME_ONLY];
  wire       fsi_write   = (fsi == FSI_WRITE_BASE);
  wire       bottom      = (pic_struct == STRUCT_BOTTOM);
  wire [1:0] chroma      = out_word[BIT_CHROMA_HI:BIT_CHROMA_LO];
  wire [7:0] resid       = out_word[BIT_RESID_HI:BIT_RESID_LO];

  // Structure code 10, index out of range, non-existing marker,
  // unaligned offset, unsupported chroma, missing direct inference, clear mono weight bit
  wire bad_struct  = (pic_struct == STRUCT_BAD);
  wire bad_fsi     = (fsi > FSI_MAX)
                  || (fsi[BIT_FSI_TOP_HI:BIT_FSI_TOP_LO] != 3'h0)
                  || (fsi[6:0] == FSI_NONEXIST);
  wire bad_resid   = ((resid[2:0] & RESID_ALIGN_MASK) != RESID_ALIGN_ZERO);
  wire bad_chroma  = chroma[1];
  wire bad_infer   = !frame_only && !out_word[BIT_DIRECT_INFER];
  wire bad_mono    = !pic_word[BIT_MONO_WEIGHT];

  wire          read_set_sel = !fsi_write;
  mv_base_sel_t next_mv_sel;
  assign next_mv_sel = read_set_sel ? MV_BASE_READ_SET :
                       (bottom ? MV_BASE_WRITE_BOTTOM : MV_BASE_WRITE_TOP);
  // Read set holds top/bottom pairs: entry = 2*index + bottom
  wire [4:0] next_rd_entry = {fsi[3:0], bottom};

  // Sync flag per macroblock: overwrite uses the intra rule
  wire intra_sync = i_mb_intra && !i_mb_pcm && i_mb_neighbour_avail;
  wire next_sync  = out_word[BIT_SYNC_OVR] ? intra_sync
                                           : out_word[BIT_SYNC];

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cmd_scan_special            <= 1'b0;
      o_data_scan_special           <= 1'b0;
      o_scaling_matrix_present      <= 1'b0;
      o_scaling_payload_accept      <= 1'b0;
      o_use_flat_8x8                <= 1'b0;
      o_picture_structure           <= STRUCT_FRAME;
      o_field_picture               <= 1'b0;
      o_current_frame_store_index   <= 8'h00;
      o_order_count_index           <= 5'h00;
      o_mv_base_select              <= MV_BASE_READ_SET;
      o_mv_read_base_entry          <= 5'h00;
      o_residual_offset             <= 8'h00;
      o_mb_sync                     <= 1'b0;
      o_sixteen_vector_format_enable <= 1'b0;
      o_mv_size_large               <= 1'b0;
      o_chroma_sampling_format      <= CHROMA_MONO;
      o_monochrome                  <= 1'b1;
      o_deblock_info_write_enable   <= 1'b0;
      o_entropy_cabac               <= 1'b0;
      o_non_reference_picture       <= 1'b0;
      o_constrained_intra           <= 1'b0;
      o_direct_block_inference      <= 1'b0;
      o_large_transform_allowed     <= 1'b0;
      o_state_valid                 <= 1'b0;
      o_field_error                 <= 1'b0;
    end else begin
      o_cmd_scan_special            <= pic_word[BIT_CMD_SCAN];
      o_data_scan_special           <= pic_word[BIT_DATA_SCAN];
      o_scaling_matrix_present      <= pic_word[BIT_SCALING];
      // Matrix payload is parsed upstream but dropped when absent
      o_scaling_payload_accept      <= pic_word[BIT_SCALING];
      o_use_flat_8x8                <= !pic_word[BIT_SCALING] && large_xform;
      o_picture_structure           <= pic_struct;
      o_field_picture               <= pic_struct[0];
      o_current_frame_store_index   <= fsi;
      o_order_count_index           <= fsi[4:0];
      o_mv_base_select              <= next_mv_sel;
      o_mv_read_base_entry          <= next_rd_entry;
      o_residual_offset             <= resid;
      o_mb_sync                     <= next_sync;
      o_sixteen_vector_format_enable <= out_word[BIT_SIXTEEN_MV];
      // Without the sixteen-vector format a large size folds to 32-vector
      o_mv_size_large               <= i_mb_large_mv && out_word[BIT_SIXTEEN_MV];
      o_chroma_sampling_format      <= chroma;
      o_monochrome                  <= (chroma == CHROMA_MONO);
      o_deblock_info_write_enable   <= out_word[BIT_DEBLOCK];
      o_entropy_cabac               <= out_word[BIT_ENTROPY];
      o_non_reference_picture       <= out_word[BIT_NON_REF];
      o_constrained_intra           <= out_word[BIT_CONSTR_INTRA];
      o_direct_block_inference      <= out_word[BIT_DIRECT_INFER];
      o_large_transform_allowed     <= large_xform;
      if (take_last) begin
        o_state_valid <= 1'b1;
      end
      o_field_error <= o_state_valid && (bad_struct || bad_fsi || bad_resid
                       || bad_chroma || bad_infer || bad_mono);
    end
  end

endmodule // pic_state_decoder

/* verilog/pic_state_streamer.sv */
// Issuing end: builds and sends the picture-state command words
`timescale 1ns/1ps
module pic_state_streamer
  import pic_state_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  // Software request
  input  wire logic          i_start,
  input  wire logic [31:0]   i_word3,
  input  wire logic [31:0]   i_word4,
  input  wire logic [31:0]   i_other_word,
  // Command link
  pic_state_if.streamer      cmd,
  // Status
  output logic               o_busy,
  output logic               o_need_matrix_cmd,
  output logic               o_done
);
  import pic_state_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND} state_t;

  state_t      state;
  logic [2:0]  idx;
  logic [31:0] w3;
  logic [31:0] w4;
  logic [31:0] wo;

  // ----------------------------------------------------------------
  // Word shaping
  // ----------------------------------------------------------------
  wire [7:0]  raw_fsi = i_word3[BIT_FSI_HI:BIT_FSI_LO];
  // Out-of-range or marker indices fall back to the write-base index
  wire        fsi_ok  = (raw_fsi <= FSI_MAX);
  wire [7:0]  use_fsi = fsi_ok ? raw_fsi : FSI_WRITE_BASE;
  wire [1:0]  raw_st  = i_word3[BIT_STRUCT_HI:BIT_STRUCT_LO];
  wire [1:0]  use_st  = (raw_st == STRUCT_BAD) ? STRUCT_FRAME : raw_st;
  // Inference and frame-only share the output word, clear of the index bits
  wire        infer   = i_word4[BIT_DIRECT_INFER] || !i_word4[BIT_FRAME_ONLY];
  wire [31:0] next_w3 = {i_word3[31:13], 1'b1, i_word3[11:10], use_st, use_fsi};
  wire [31:0] fix_w4  = {i_word4[31:27], 3'h0, i_word4[23:0]};
  wire [31:0] next_w4 = {fix_w4[31:12], 1'b0, fix_w4[10:5], infer, fix_w4[3:0]};
  wire [31:0] word_out = (idx == WORD_IDX_PIC) ? w3 :
                         (idx == WORD_IDX_OUT) ? w4 : wo;
  wire        step     = cmd.valid && cmd.ready;
  wire        at_last  = (idx == 3'(CMD_WORDS - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state             <= ST_IDLE;
      idx               <= 3'h0;
      w3                <= RST_WORD;
      w4                <= RST_WORD;
      wo                <= RST_WORD;
      cmd.valid         <= 1'b0;
      cmd.data          <= RST_WORD;
      cmd.last          <= 1'b0;
      o_busy            <= 1'b0;
      o_need_matrix_cmd <= 1'b0;
      o_done            <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            w3                <= next_w3;
            w4                <= next_w4;
            wo                <= i_other_word;
            idx               <= 3'h0;
            o_busy            <= 1'b1;
            // A matrix command must follow when matrices are present
            o_need_matrix_cmd <= i_word3[BIT_SCALING];
            state             <= ST_SEND;
          end
        end
        ST_SEND: begin
          cmd.valid <= !(step && cmd.last);
          cmd.data  <= word_out;
          cmd.last  <= at_last;
          if (step && cmd.last) begin
            state  <= ST_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end else if (!cmd.valid || step) begin
            idx <= at_last ? idx : idx + 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pic_state_streamer

/* test/pic_state_sva.sv */
// Checker: wire-level rules on the command link between the two ends
`timescale 1ns/1ps
module pic_state_sva (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Link signals
  input  wire logic        valid,
  input  wire logic        ready,
  input  wire logic [31:0] data,
  input  wire logic        last
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Word position in a command, restarted after the final word
  logic [2:0] word_idx;
  always_ff @(posedge i_clock) begin
    if (i_rst || (valid && last)) word_idx <= 3'h0;
    else if (valid) word_idx <= word_idx + 3'h1;
  end

  chk_mono_weight: assert property (valid && word_idx == 3'h3 |-> data[12])
    else $error("picture word bit 12 not set");
  chk_struct_legal: assert property (valid && word_idx == 3'h3 |-> data[9:8] != 2'h2)
    else $error("forbidden picture structure sent");
  chk_index_range: assert property (valid && word_idx == 3'h3 |-> data[7:0] <= 8'h10)
    else $error("frame store index out of range");
  chk_direct_infer: assert property (valid && word_idx == 3'h4 && !data[2] |-> data[4])
    else $error("direct inference clear without frame-only");
  chk_resid_align: assert property (valid && word_idx == 3'h4 |-> data[26:24] == 3'h0)
    else $error("residual offset not aligned");
  chk_chroma_legal: assert property (valid && word_idx == 3'h4 |-> !data[11])
    else $error("unsupported chroma format sent");
  chk_last_place: assert property (valid && (last || word_idx == 3'h7) |-> last && word_idx == 3'h7)
    else $error("final word marker misplaced");
  chk_frame_run: assert property (valid && !last |=> valid)
    else $error("gap inside a command");
  chk_frame_start: assert property ($rose(valid) |-> word_idx == 3'h0 ##7 (valid && last))
    else $error("command not eight words long");
  chk_ready_high: assert property (valid |-> ready)
    else $error("decoder not ready");
endmodule // pic_state_sva

/* test/avc_picture_state_fields_test.sv */
// Testbench: streamer and decoder joined over the command link
`timescale 1ns/1ps
module avc_picture_state_fields_test;
  import pic_state_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic         i_clock = 1'b0;
  logic         i_rst = 1'b1;
  logic         start = 1'b0;
  logic [31:0]  word3 = 32'h0000_0000;
  logic [31:0]  word4 = 32'h0000_0000;
  logic [31:0]  other = 32'h0000_0000;
  logic         mb_intra = 1'b0, mb_pcm = 1'b0, mb_nb = 1'b0, mb_large = 1'b0;
  logic         cmd_scan, data_scan, sm_present, payload_acc, flat8, field_pic, mb_sync;
  logic         sixteen, mv_large, mono, deblock, cabac, nonref, constr, direct;
  logic         large_xf, st_valid, f_err, need_qm, done, busy;
  logic [1:0]   pic_struct, chroma;
  logic [7:0]   fs_idx, resid;
  logic [4:0]   oc_idx, rd_entry;
  mv_base_sel_t base_sel;
  logic [31:0]  e3, e4, w3, w4;
  logic [7:0]   idx_tab [6] = '{8'h00, 8'h0F, 8'h10, 8'h2B, 8'h7F, 8'h06};
  integer       miscompares = 0;
  integer       num_checks = 0;
  integer       cycles = 0;
  integer       k;

  always #12.5 i_clock = ~i_clock;

  // ------------------------------------------------------------
  // Both ends and the checker
  // ------------------------------------------------------------
  pic_state_if link ();
  pic_state_streamer pic_state_streamer_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_start(start), .i_word3(word3), .i_word4(word4), .i_other_word(other),
    .cmd(link), .o_busy(busy), .o_need_matrix_cmd(need_qm), .o_done(done));
  pic_state_decoder pic_state_decoder_i (.i_clock(i_clock), .i_rst(i_rst), .cmd(link),
    .i_mb_intra(mb_intra), .i_mb_pcm(mb_pcm), .i_mb_neighbour_avail(mb_nb),
    .i_mb_large_mv(mb_large), .o_cmd_scan_special(cmd_scan), .o_data_scan_special(data_scan),
    .o_scaling_matrix_present(sm_present), .o_scaling_payload_accept(payload_acc),
    .o_use_flat_8x8(flat8), .o_picture_structure(pic_struct), .o_field_picture(field_pic),
    .o_current_frame_store_index(fs_idx), .o_order_count_index(oc_idx),
    .o_mv_base_select(base_sel), .o_mv_read_base_entry(rd_entry), .o_residual_offset(resid),
    .o_mb_sync(mb_sync), .o_sixteen_vector_format_enable(sixteen), .o_mv_size_large(mv_large),
    .o_chroma_sampling_format(chroma), .o_monochrome(mono),
    .o_deblock_info_write_enable(deblock), .o_entropy_cabac(cabac),
    .o_non_reference_picture(nonref), .o_constrained_intra(constr),
    .o_direct_block_inference(direct), .o_large_transform_allowed(large_xf),
    .o_state_valid(st_valid), .o_field_error(f_err));
  pic_state_sva pic_state_sva_i (.i_clock(i_clock), .i_rst(i_rst), .valid(link.valid),
    .ready(link.ready), .data(link.data), .last(link.last));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Words as the streamer must clean them before they reach the wire
  task automatic send(input logic [31:0] a3, input logic [31:0] a4);
    integer n;
    @(posedge i_clock);
    start <= 1'b1;
    word3 <= a3;
    word4 <= a4;
    other <= $urandom;
    @(posedge i_clock);
    start <= 1'b0;
    e3 = a3;
    e4 = a4;
    e3[12] = 1'b1;
    if (e3[9:8] == STRUCT_BAD) e3[9:8] = STRUCT_FRAME;
    if (e3[7:0] > FSI_MAX) e3[7:0] = FSI_MAX;
    if (!e4[2]) e4[4] = 1'b1;
    e4[26:24] = 3'h0;
    e4[11] = 1'b0;
    @(negedge i_clock);
    check({busy, done}, 2'h2);
    for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge i_clock);
    check(done, 1'b1);
    check(busy, 1'b0);
  endtask

  task automatic fields;
    logic [1:0] sel;
    sel = (e3[7:0] != FSI_WRITE_BASE) ? 2'h0 : (e3[9:8] == STRUCT_BOTTOM) ? 2'h2 : 2'h1;
    check(cmd_scan, e3[14]);
    check(data_scan, e3[13]);
    check({sm_present, payload_acc, flat8}, {e3[10], e3[10], !e3[10] & e4[3]});
    check(need_qm, e3[10]);
    check({pic_struct, field_pic}, {e3[9:8], e3[8]});
    check(fs_idx, e3[7:0]);
    check(base_sel, sel);
    if (e3[7:0] < FSI_WRITE_BASE) check(rd_entry, {e3[3:0], e3[9:8] == STRUCT_BOTTOM});
    check(oc_idx, e3[4:0]);
    check(resid, e4[31:24]);
    check(sixteen, e4[12]);
    check({chroma, mono}, {e4[11:10], e4[11:10] == CHROMA_MONO});
    check(deblock, e4[8]);
    check(cabac, e4[7]);
    check(nonref, e4[6]);
    check(constr, e4[5]);
    check({direct, large_xf}, {e4[4], e4[3]});
    check({st_valid, f_err}, 2'h2);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(70046));
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    for (k = 0; k < 24; k++) begin
      w3 = $urandom;
      w4 = $urandom;
      w3[9:8] = k[1:0];
      w3[7:0] = idx_tab[k % 6];
      w4[11:10] = k[3:2];
      w4[17] = k[0];
      send(w3, w4);
      fields();
      for (int m = 0; m < 16; m++) begin
        @(posedge i_clock);
        {mb_intra, mb_pcm, mb_nb, mb_large} <= 4'(m);
        @(posedge i_clock);
        @(negedge i_clock);
        check(mb_sync, e4[17] ? (mb_intra & !mb_pcm & mb_nb) : e4[16]);
        check(mv_large, mb_large & e4[12]);
      end
      if (k == 11) begin
        // Input words change without a start: the held state must not move
        @(posedge i_clock);
        word3 <= ~w3;
        word4 <= ~w4;
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
        fields();
      end
      if (k == 17) begin
        @(posedge i_clock);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        check({st_valid, mono, fs_idx, need_qm}, {2'h1, 8'h00, 1'b0});
      end
    end
    end_of_test();
  end
endmodule // avc_picture_state_fields_test
